//--- core/pafm_datapath.v
`timescale 1ns/100ps
`include "pafm_defs.vh"

// Contract
// RQ1 - Software supplies a one-bit-per-pel boundary map.
// RQ2 - Software clears the boundary map before drawing.
// RQ3 - Plain fill uses keep-destination background mix.
// RQ4 - Area fill uses an X-increasing direction code.
// RQ5 - Fill forces pels foreground between boundary pels.
// RQ6 - Pattern one picks foreground, zero background.
// RQ7 - Area fill consumes the pattern; no user pattern.
// RQ8 - Patterned fill stage one builds a mask.
// RQ9 - Stage one copies source, zero background colour.
// RQ10 - Stage two uses the combined mask map.
// RQ11 - Foreground, background sources chosen independently.
// RQ12 - Fixed colours come from two colour registers.
// RQ13 - New destination is old destination mixed with source.
// RQ14 - Mask zero keeps destination; one applies mix.
// RQ15 - Foreground and background mixes chosen independently.
// RQ16 - Codes 00 to 0F are the logic functions.
// RQ17 - Codes 10 to 15 are arithmetic functions.
// RQ18 - Software avoids reserved mix codes 16 to FF.
// RQ19 - Arithmetic saturates at all ones and zero.
// RQ20 - Writing the top pel-op byte starts operation.
// RQ21 - Fill state clears at each line start.
// RQ22 - Average is the truncated half sum.
module pafm_datapath #(
   parameter PEL_W = 8
) (
   input  wire             clk_i,
   input  wire             rst_i,
   // Wishbone classic slave.
   input  wire             cyc_i,
   input  wire             stb_i,
   input  wire             we_i,
   input  wire [7:0]       adr_i,
   input  wire [3:0]       sel_i,
   input  wire [31:0]      dat_i,
   output reg  [31:0]      dat_o,
   output reg              ack_o,
   // Pel fetch side: one source, destination, pattern and mask pel per transfer.
   input  wire             pel_valid_i,
   output wire             pel_ready_o,
   input  wire [PEL_W-1:0] pel_src_i,
   input  wire [PEL_W-1:0] pel_dst_i,
   input  wire             pel_pattern_i,
   input  wire             pel_mask_i,
   // Result side: one destination pel per transfer.
   output reg              res_valid_o,
   input  wire             res_ready_i,
   output reg  [PEL_W-1:0] res_data_o,
   output reg              res_write_o,
   output reg              res_line_end_o,
   output reg              res_last_o,
   output wire             busy_o
);

   // Merges a write into a register under its byte enables.
   function [31:0] wb_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel_v;
      integer      i;
      begin
         wb_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel_v[i]) begin
               wb_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // Address decode used by both the write and the read paths.
   function is_adr;
      input [7:0] a;
      input [7:0] ref_v;
      begin
         is_adr = (a[7:2] == ref_v[7:2]);
      end
   endfunction

   // Two states suffice: the pel stream itself paces the scan, so no fetch sequencing lives here.
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg  [31:0]      pel_op_q;
   reg  [7:0]       fg_mix_q;
   reg  [7:0]       bg_mix_q;
   reg  [31:0]      fg_color_q;
   reg  [31:0]      bg_color_q;
   reg  [31:0]      dim_q;
   reg              state_q;
   reg  [15:0]      x_q;
   reg  [15:0]      y_q;
   reg  [PEL_W-1:0] res_data_d;
   reg              res_write_d;

   wire             req_w;
   wire             wr_w;
   wire             start_w;
   wire             accept_w;
   wire             line_start_w;
   wire             line_end_w;
   wire             last_w;
   wire             fill_en_w;
   wire             filled_w;
   wire             fill_state_w;
   wire             use_fg_w;
   wire [PEL_W-1:0] fg_src_w;
   wire [PEL_W-1:0] bg_src_w;
   wire [PEL_W-1:0] fg_res_w;
   wire [PEL_W-1:0] bg_res_w;
   wire             mask_w;
   wire [15:0]      width_w;
   wire [15:0]      height_w;
   wire [31:0]      status_w;

   // ---------------------------------------------------------------- Bus slave.
   // Every access is answered one cycle after it is seen; unmapped reads return zero.
   // Writes that arrive while busy are still acknowledged, so software never stalls on the bus,
   // but they are dropped; the status word ignores writes at all times.
   assign req_w = cyc_i & stb_i & ~ack_o;
   assign wr_w  = req_w & we_i;

   // A write that reaches the top byte of the pel-op register starts work, but only when idle,
   // so a second start cannot corrupt a running operation.
   assign start_w = wr_w & is_adr(adr_i, `PAFM_ADR_PEL_OP) &
                    sel_i[`PAFM_OP_START_SEL] & (state_q == ST_IDLE); // RQ20

   // The ack is registered and masks the request for its own cycle, which stops a strobe that is
   // still held in the ack cycle from being answered twice.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req_w;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pel_op_q   <= `PAFM_RST_PEL_OP;
         fg_mix_q   <= `PAFM_RST_MIX;
         bg_mix_q   <= `PAFM_RST_MIX;
         fg_color_q <= `PAFM_RST_COLOR;
         bg_color_q <= `PAFM_RST_COLOR;
         dim_q      <= `PAFM_RST_DIM;
      end else if (wr_w) begin
         // Settings are frozen while an operation runs so every pel sees one configuration.
         if (state_q == ST_IDLE) begin
            if (is_adr(adr_i, `PAFM_ADR_PEL_OP)) begin
               pel_op_q <= wb_merge(pel_op_q, dat_i, sel_i);
            end
            if (is_adr(adr_i, `PAFM_ADR_FG_MIX) && sel_i[0]) begin
               fg_mix_q <= dat_i[7:0]; // RQ15
            end
            if (is_adr(adr_i, `PAFM_ADR_BG_MIX) && sel_i[0]) begin
               bg_mix_q <= dat_i[7:0]; // RQ15
            end
            if (is_adr(adr_i, `PAFM_ADR_FG_COLOR)) begin
               fg_color_q <= wb_merge(fg_color_q, dat_i, sel_i); // RQ12
            end
            if (is_adr(adr_i, `PAFM_ADR_BG_COLOR)) begin
               bg_color_q <= wb_merge(bg_color_q, dat_i, sel_i); // RQ12
            end
            if (is_adr(adr_i, `PAFM_ADR_DIM)) begin
               dim_q <= wb_merge(dim_q, dat_i, sel_i);
            end
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req_w && !we_i) begin
         if (is_adr(adr_i, `PAFM_ADR_PEL_OP)) begin
            dat_o <= pel_op_q;
         end else if (is_adr(adr_i, `PAFM_ADR_FG_MIX)) begin
            dat_o <= {24'h00_0000, fg_mix_q};
         end else if (is_adr(adr_i, `PAFM_ADR_BG_MIX)) begin
            dat_o <= {24'h00_0000, bg_mix_q};
         end else if (is_adr(adr_i, `PAFM_ADR_FG_COLOR)) begin
            dat_o <= fg_color_q;
         end else if (is_adr(adr_i, `PAFM_ADR_BG_COLOR)) begin
            dat_o <= bg_color_q;
         end else if (is_adr(adr_i, `PAFM_ADR_DIM)) begin
            dat_o <= dim_q;
         end else if (is_adr(adr_i, `PAFM_ADR_STATUS)) begin
            dat_o <= status_w;
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end else begin
         dat_o <= 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------- Scan control.
   // Width and height hold the count minus one, so a one-pel operation is legal and no value
   // describes an empty area.
   assign width_w  = dim_q[`PAFM_DIM_W_MSB:`PAFM_DIM_W_LSB];
   assign height_w = dim_q[`PAFM_DIM_H_MSB:`PAFM_DIM_H_LSB];
   assign busy_o   = state_q;

   // Status is built live from the scan state rather than copied, so a poll never sees a stale
   // busy bit or line number.
   assign status_w[`PAFM_ST_BUSY_BIT]                       = state_q;
   assign status_w[`PAFM_ST_FILL_BIT]                       = fill_state_w;
   assign status_w[`PAFM_ST_LINE_LSB-1:`PAFM_ST_FILL_BIT+1] = 14'h0000;
   assign status_w[31:`PAFM_ST_LINE_LSB]                    = y_q;

   // Limitation: the direction bits are only stored. The fetch side must present pels in scan
   // order, left to right within a line, or the fill toggles at the wrong pels.
   // A new pel is taken only when the result stage is free or draining this cycle.
   assign pel_ready_o  = (state_q == ST_RUN) & (~res_valid_o | res_ready_i);
   assign accept_w     = pel_valid_i & pel_ready_o;
   assign line_start_w = (x_q == 16'h0000);
   assign line_end_w   = (x_q == width_w);
   // Busy drops at the edge that takes the last pel; that pel's result may still wait at the sink.
   assign last_w       = line_end_w & (y_q == height_w);

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         x_q     <= 16'h0000;
         y_q     <= 16'h0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_w) begin
                  state_q <= ST_RUN;
                  x_q     <= 16'h0000;
                  y_q     <= 16'h0000;
               end
            end
            ST_RUN: begin
               if (accept_w) begin
                  if (line_end_w) begin
                     x_q <= 16'h0000;
                     if (last_w) begin
                        state_q <= ST_IDLE;
                     end else begin
                        y_q <= y_q + 16'h0001;
                     end
                  end else begin
                     x_q <= x_q + 16'h0001;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------- Pel datapath.
   // In area fill the pattern stream is the boundary map, so no user pattern can be mixed in.
   assign fill_en_w = (pel_op_q[`PAFM_OP_FUNC_MSB:`PAFM_OP_FUNC_LSB] == `PAFM_FUNC_FILL); // RQ7

   // The fill unit advances only on accepted pels, so its state follows the scan exactly; the
   // start write clears it, so a fill left open by an earlier operation cannot leak into this one.
   pafm_fill_unit u_fill (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .clear_i      (start_w),
      .enable_i     (fill_en_w),
      .advance_i    (accept_w),
      .line_start_i (line_start_w),
      .pattern_i    (pel_pattern_i),
      .filled_o     (filled_w),
      .fill_state_o (fill_state_w)
   );

   // Once shaped by the fill unit the pattern is used exactly like a user pattern.
   assign use_fg_w = filled_w; // RQ6

   // Each side independently takes either its fixed colour or the source map pel.
   assign fg_src_w = pel_op_q[`PAFM_OP_FG_SRC_BIT] ? pel_src_i : fg_color_q[PEL_W-1:0]; // RQ11
   assign bg_src_w = pel_op_q[`PAFM_OP_BG_SRC_BIT] ? pel_src_i : bg_color_q[PEL_W-1:0]; // RQ11

   // Two mix units let either code change without muxing the code into one unit's critical path.
   pafm_mix_unit #(
      .PEL_W (PEL_W)
   ) u_fg_mix (
      .code_i (fg_mix_q),
      .src_i  (fg_src_w),
      .dst_i  (pel_dst_i),
      .res_o  (fg_res_w)
   );

   pafm_mix_unit #(
      .PEL_W (PEL_W)
   ) u_bg_mix (
      .code_i (bg_mix_q),
      .src_i  (bg_src_w),
      .dst_i  (pel_dst_i),
      .res_o  (bg_res_w)
   );

   // With the mask facility off every pel is treated as unmasked.
   assign mask_w = pel_op_q[`PAFM_OP_MASK_BIT] ? pel_mask_i : 1'b1;

   // Next result pel and write flag: a masked pel passes the old destination through unwritten.
   always @* begin
      res_data_d  = pel_dst_i; // RQ14
      res_write_d = 1'b0;
      if (mask_w) begin
         res_write_d = 1'b1; // RQ14
         if (use_fg_w) begin
            res_data_d = fg_res_w; // RQ13
         end else begin
            res_data_d = bg_res_w; // RQ13
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         res_valid_o    <= 1'b0;
         res_data_o     <= {PEL_W{1'b0}};
         res_write_o    <= 1'b0;
         res_line_end_o <= 1'b0;
         res_last_o     <= 1'b0;
      end else if (accept_w) begin
         res_valid_o    <= 1'b1;
         res_data_o     <= res_data_d; // RQ13
         res_write_o    <= res_write_d; // RQ14
         res_line_end_o <= line_end_w;
         res_last_o     <= last_w;
      end else if (res_ready_i) begin
         res_valid_o    <= 1'b0;
         res_write_o    <= 1'b0;
         res_line_end_o <= 1'b0;
         res_last_o     <= 1'b0;
      end
   end

endmodule // pafm_datapath

//--- core/pafm_defs.vh
`ifndef PAFM_DEFS_VH
`define PAFM_DEFS_VH

// Register byte offsets on the Wishbone slave; the low two address bits are ignored.
`define PAFM_ADR_PEL_OP     8'h00
`define PAFM_ADR_FG_MIX     8'h04
`define PAFM_ADR_BG_MIX     8'h08
`define PAFM_ADR_FG_COLOR   8'h0c
`define PAFM_ADR_BG_COLOR   8'h10
`define PAFM_ADR_DIM        8'h14
`define PAFM_ADR_STATUS     8'h18

// Pel operation register fields.
`define PAFM_OP_DIR_LSB     0
`define PAFM_OP_DIR_MSB     2
`define PAFM_OP_FG_SRC_BIT  8
`define PAFM_OP_BG_SRC_BIT  9
`define PAFM_OP_MASK_BIT    16
`define PAFM_OP_FUNC_LSB    24
`define PAFM_OP_FUNC_MSB    27
`define PAFM_OP_START_SEL   3

// Function field values.
`define PAFM_FUNC_BLOCK     4'h0
`define PAFM_FUNC_FILL      4'h1

// Dimension register fields, each holding the count minus one.
`define PAFM_DIM_W_LSB      0
`define PAFM_DIM_W_MSB      15
`define PAFM_DIM_H_LSB      16
`define PAFM_DIM_H_MSB      31

// Status register fields.
`define PAFM_ST_BUSY_BIT    0
`define PAFM_ST_FILL_BIT    1
`define PAFM_ST_LINE_LSB    16

// Mix codes.
`define PAFM_MIX_DEST       8'h05
`define PAFM_MIX_MAX        8'h10
`define PAFM_MIX_MIN        8'h11
`define PAFM_MIX_ADD        8'h12
`define PAFM_MIX_SUB_DS     8'h13
`define PAFM_MIX_SUB_SD     8'h14
`define PAFM_MIX_AVG        8'h15

// Reset values.
`define PAFM_RST_PEL_OP     32'h0000_0000
`define PAFM_RST_MIX        8'h05
`define PAFM_RST_COLOR      32'h0000_0000
`define PAFM_RST_DIM        32'h0000_0000

`endif

//--- core/pafm_fill_unit.v
`timescale 1ns/100ps

// Horizontal fill of one pattern line, scanned left to right.
module pafm_fill_unit (
   input  wire clk_i,
   input  wire rst_i,
   input  wire clear_i,
   input  wire enable_i,
   input  wire advance_i,
   input  wire line_start_i,
   input  wire pattern_i,
   output wire filled_o,
   output wire fill_state_o
);

   reg  fill_q;
   wire fill_cur = line_start_i ? 1'b0 : fill_q; // RQ21

   // A boundary pel is itself foreground and toggles filling for the pels after it.
   assign filled_o     = enable_i ? (pattern_i | fill_cur) : pattern_i; // RQ5
   assign fill_state_o = fill_q;

   always @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         fill_q <= 1'b0;
      end else if (advance_i) begin
         fill_q <= enable_i & (fill_cur ^ pattern_i); // RQ5
      end
   end

endmodule // pafm_fill_unit

//--- core/pafm_mix_unit.v
`timescale 1ns/100ps
`include "pafm_defs.vh"

// Combinational mix of one source pel with one destination pel.
module pafm_mix_unit #(
   parameter PEL_W = 8
) (
   input  wire [7:0]       code_i,
   input  wire [PEL_W-1:0] src_i,
   input  wire [PEL_W-1:0] dst_i,
   output reg  [PEL_W-1:0] res_o
);

   wire [PEL_W:0] sum_w    = {1'b0, src_i} + {1'b0, dst_i};
   wire [PEL_W:0] d_min_s  = {1'b0, dst_i} - {1'b0, src_i};
   wire [PEL_W:0] s_min_d  = {1'b0, src_i} - {1'b0, dst_i};
   wire [PEL_W-1:0] logic_w;

   // The four low code bits are a truth table indexed by inverted source and destination.
   genvar g;
   generate
      for (g = 0; g < PEL_W; g = g + 1) begin : g_logic
         assign logic_w[g] = code_i[{~src_i[g], ~dst_i[g]}]; // RQ16
      end
   endgenerate

   always @* begin
      case (code_i)
         `PAFM_MIX_MAX:    res_o = (src_i > dst_i) ? src_i : dst_i; // RQ17
         `PAFM_MIX_MIN:    res_o = (src_i < dst_i) ? src_i : dst_i; // RQ17
         `PAFM_MIX_ADD:    res_o = sum_w[PEL_W] ? {PEL_W{1'b1}} : sum_w[PEL_W-1:0]; // RQ19
         `PAFM_MIX_SUB_DS: res_o = d_min_s[PEL_W] ? {PEL_W{1'b0}} : d_min_s[PEL_W-1:0]; // RQ19
         `PAFM_MIX_SUB_SD: res_o = s_min_d[PEL_W] ? {PEL_W{1'b0}} : s_min_d[PEL_W-1:0]; // RQ19
         `PAFM_MIX_AVG:    res_o = sum_w[PEL_W:1]; // RQ22
         default: begin
            // Reserved codes leave the destination untouched rather than guess a function.
            if (code_i[7:4] == 4'h0) begin
               res_o = logic_w;
            end else begin
               res_o = dst_i;
            end
         end
      endcase
   end

endmodule // pafm_mix_unit

//--- verification/pafm_checker_sva.sv
`timescale 1ns/100ps

// Watches the bus handshake and the pel stream at the datapath's ports.
module pafm_checker #(
   parameter PEL_W = 8
) (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             cyc_i,
   input wire logic             stb_i,
   input wire logic             we_i,
   input wire logic [7:0]       adr_i,
   input wire logic [3:0]       sel_i,
   input wire logic [31:0]      dat_o,
   input wire logic             ack_o,
   input wire logic             pel_valid_i,
   input wire logic             pel_ready_o,
   input wire logic [PEL_W-1:0] pel_dst_i,
   input wire logic             res_valid_o,
   input wire logic             res_ready_i,
   input wire logic [PEL_W-1:0] res_data_o,
   input wire logic             res_write_o,
   input wire logic             res_last_o,
   input wire logic             busy_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_take;
      pel_valid_i && pel_ready_o;
   endsequence

   property p_ack;
      s_req |=> ack_o;
   endproperty
   property p_pulse;
      ack_o |=> !ack_o;
   endproperty
   property p_dat_idle;
      !ack_o |-> dat_o == 32'h0000_0000;
   endproperty
   // The start is the top byte of the operation register, written while idle.
   property p_start;
      (s_req ##0 (we_i && sel_i[3] && adr_i[7:2] == 6'h00 && !busy_o)) |=> busy_o;
   endproperty
   property p_ready;
      pel_ready_o == (busy_o && (!res_valid_o || res_ready_i));
   endproperty
   property p_result;
      s_take |=> res_valid_o;
   endproperty
   property p_hold;
      (res_valid_o && !res_ready_i) |=> (res_valid_o && $stable(res_data_o));
   endproperty
   property p_mask;
      (s_take ##1 !res_write_o) |-> res_data_o == $past(pel_dst_i);
   endproperty
   property p_last;
      (res_valid_o && res_last_o) |-> !busy_o;
   endproperty

   a_ack:      assert property (p_ack) else $error("bus access not acked next cycle");
   a_pulse:    assert property (p_pulse) else $error("ack longer than one cycle");
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   a_start:    assert property (p_start) else $error("start write did not start");
   a_ready:    assert property (p_ready) else $error("pel ready wrong");
   a_result:   assert property (p_result) else $error("no result after pel");
   a_hold:     assert property (p_hold) else $error("stalled result changed");
   a_mask:     assert property (p_mask) else $error("masked pel modified");
   a_last:     assert property (p_last) else $error("busy after last pel");
endmodule // pafm_checker

bind pafm_datapath pafm_checker #(.PEL_W(PEL_W)) i_pafm_checker (
   .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_o, .ack_o,
   .pel_valid_i, .pel_ready_o, .pel_dst_i, .res_valid_o, .res_ready_i,
   .res_data_o, .res_write_o, .res_last_o, .busy_o
);

//--- verification/pafm_datapath_tb_top.sv
`timescale 1ns/100ps
`include "pafm_defs.vh"

module pafm_datapath_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic        pel_valid_i = 1'b0, pel_pattern_i = 1'b0, pel_mask_i = 1'b0;
   logic        res_ready_i = 1'b0;
   logic [7:0]  adr_i = 8'h00, pel_src_i = 8'h00, pel_dst_i = 8'h00, res_data_o;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic        ack_o, pel_ready_o, res_valid_o, res_write_o, res_line_end_o;
   logic        res_last_o, busy_o;
   int          errors = 0;
   int          check_count = 0;

   pafm_datapath #(.PEL_W(8)) i_pafm_datapath (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .pel_valid_i, .pel_ready_o, .pel_src_i, .pel_dst_i, .pel_pattern_i, .pel_mask_i,
      .res_valid_o, .res_ready_i, .res_data_o, .res_write_o, .res_line_end_o,
      .res_last_o, .busy_o
   );

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task conclude;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] a, input logic [31:0] e);
      check_count++;
      if (a !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
   endtask

   // Drives land just after a rising edge; ack and read data are taken at the rising edge that
   // samples ack high, while settled stream outputs are looked at on the falling edge.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   // The result is held back a cycle on purpose, so every pel sees a stalled sink.
   task pel(input logic [7:0] s, input logic [7:0] d, input logic p, input logic m,
            input logic [7:0] e, input logic [1:0] f);
      @(posedge clk_i);
      pel_valid_i <= 1'b1;
      pel_src_i <= s;
      pel_dst_i <= d;
      pel_pattern_i <= p;
      pel_mask_i <= m;
      @(posedge clk_i);
      while (pel_ready_o !== 1'b1) @(posedge clk_i);
      pel_valid_i <= 1'b0;
      pel_src_i <= ~s;
      pel_dst_i <= ~d;
      @(negedge clk_i);
      chk(res_valid_o, 1);
      chk(res_data_o, e);
      chk(res_write_o, m);
      chk({res_line_end_o, res_last_o}, f);
      @(posedge clk_i);
      res_ready_i <= 1'b1;
      @(posedge clk_i);
      res_ready_i <= 1'b0;
   endtask

   function automatic logic [7:0] mix(input logic [7:0] c, input logic [7:0] s,
                                      input logic [7:0] d);
      logic [8:0] t;
      t = {1'b0, s} + {1'b0, d};
      case (c)
         8'h00: mix = 8'h00;
         8'h01: mix = s & d;
         8'h02: mix = s & ~d;
         8'h03: mix = s;
         8'h04: mix = ~s & d;
         8'h05: mix = d;
         8'h06: mix = s ^ d;
         8'h07: mix = s | d;
         8'h08: mix = ~s & ~d;
         8'h09: mix = s ^ ~d;
         8'h0a: mix = ~d;
         8'h0b: mix = s | ~d;
         8'h0c: mix = ~s;
         8'h0d: mix = ~s | d;
         8'h0e: mix = ~s | ~d;
         8'h0f: mix = 8'hff;
         8'h10: mix = (s > d) ? s : d;
         8'h11: mix = (s < d) ? s : d;
         8'h12: mix = t[8] ? 8'hff : t[7:0];
         8'h13: mix = (d > s) ? d - s : 8'h00;
         8'h14: mix = (s > d) ? s - d : 8'h00;
         8'h15: mix = t[8:1];
         default: mix = d;
      endcase
   endfunction

   task t_reset;
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, (i == 1 || i == 2) ? 32'h5 : 32'h0);
      end
   endtask

   task t_mix;
      wb(1'b1, `PAFM_ADR_DIM, 32'h0000_0002);
      wb(1'b1, `PAFM_ADR_BG_MIX, 32'h0000_0013);
      for (logic [7:0] c = 8'h00; c <= 8'h15; c++) begin
         wb(1'b1, `PAFM_ADR_FG_MIX, {24'h0, c});
         wb(1'b1, `PAFM_ADR_PEL_OP, 32'h0000_0300);
         pel(8'hc8, 8'h5a, 1'b1, 1'b1, mix(c, 8'hc8, 8'h5a), 2'b00);
         pel(8'h30, 8'h70, 1'b1, 1'b1, mix(c, 8'h30, 8'h70), 2'b00);
         pel(8'h30, 8'h70, 1'b0, 1'b1, 8'h40, 2'b11);
      end
   endtask

   task t_color;
      wb(1'b1, `PAFM_ADR_FG_COLOR, 32'h0000_0011);
      wb(1'b1, `PAFM_ADR_BG_COLOR, 32'h0000_0022);
      wb(1'b1, `PAFM_ADR_FG_MIX, 32'h0000_0003);
      wb(1'b1, `PAFM_ADR_BG_MIX, 32'h0000_0006);
      wb(1'b1, `PAFM_ADR_PEL_OP, 32'h0001_0000);
      pel(8'h99, 8'hf0, 1'b1, 1'b1, 8'h11, 2'b00);
      pel(8'h99, 8'hf0, 1'b0, 1'b1, 8'hd2, 2'b00);
      pel(8'h99, 8'hf0, 1'b1, 1'b0, 8'hf0, 2'b11);
   endtask

   // The first line is left open so that a fill carried into the next line shows.
   task t_fill;
      logic [11:0] pat;
      logic        f;
      pat = 12'b010100_000010;
      f = 1'b0;
      wb(1'b1, `PAFM_ADR_DIM, 32'h0001_0005);
      wb(1'b1, `PAFM_ADR_BG_MIX, 32'h0000_0005);
      wb(1'b1, `PAFM_ADR_PEL_OP, 32'h0100_0000);
      for (int i = 0; i < 12; i++) begin
         if (i % 6 == 0)
            f = 1'b0;
         pel(8'h77, 8'h5a, pat[i], 1'b1, (pat[i] | f) ? 8'h11 : 8'h5a,
             {i % 6 == 5, i == 11});
         f = f ^ pat[i];
         if (i == 3) begin
            wb(1'b0, `PAFM_ADR_STATUS, 32'h0);
            chk(rd, 32'h0000_0003);
            wb(1'b1, `PAFM_ADR_FG_MIX, 32'h0000_000c);
            wb(1'b0, `PAFM_ADR_FG_MIX, 32'h0);
            chk(rd, 32'h0000_0003);
         end
      end
   endtask

   // Stage one merges the boundary fill with a user mask; stage two draws through that mask.
   task t_pfill;
      logic [5:0] bnd, usr, pat, cmb;
      logic       f;
      logic [7:0] e;
      bnd = 6'b010010;
      usr = 6'b111010;
      pat = 6'b011001;
      f = 1'b0;
      wb(1'b1, `PAFM_ADR_DIM, 32'h0000_0005);
      wb(1'b1, `PAFM_ADR_FG_MIX, 32'h0000_0003);
      wb(1'b1, `PAFM_ADR_BG_MIX, 32'h0000_0003);
      wb(1'b1, `PAFM_ADR_BG_COLOR, 32'h0000_0000);
      wb(1'b1, `PAFM_ADR_PEL_OP, 32'h0100_0100);
      for (int i = 0; i < 6; i++) begin
         cmb[i] = (bnd[i] | f) & usr[i];
         pel({7'h00, usr[i]}, {7'h00, bnd[i]}, bnd[i], 1'b1, {7'h00, cmb[i]},
             {i == 5, i == 5});
         f = f ^ bnd[i];
      end
      wb(1'b1, `PAFM_ADR_PEL_OP, 32'h0001_0000);
      for (int i = 0; i < 6; i++) begin
         e = cmb[i] ? (pat[i] ? 8'h11 : 8'h00) : 8'h5a;
         pel(8'h99, 8'h5a, pat[i], cmb[i], e, {i == 5, i == 5});
      end
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_mix;
      t_color;
      t_fill;
      t_pfill;
      conclude;
   end

   initial begin
      repeat (8000) @(posedge clk_i);
      errors++;
      conclude;
   end
endmodule // pafm_datapath_tb_top
